// ---- stall_pkg.sv ----
`default_nettype none
package stall_pkg;
    // ========================================
    // Register map
    localparam logic [31:0] CFG_OFFSET = 32'h0000_0000;
    localparam int CLK_HALVE_BIT = 5;
    localparam int RSV4_BIT = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 2;
    localparam int COUNT_HI = 1;
    localparam int COUNT_LO = 0;
    localparam int STORED_W = 6;
    localparam logic [7:0] CFG_RESET = 8'hC8;
    localparam logic [1:0] RSV_TOP_READ = 2'h3;
    localparam logic [1:0] COUNT_ONE = 2'h1;
    localparam logic [1:0] COUNT_ZERO = 2'h0;

    // ========================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // Types
    typedef enum logic [1:0] {
        MODE_PROG = 2'b00,
        MODE_NONE = 2'b01,
        MODE_PIN_EXT = 2'b10,
        MODE_PIN_TRIG = 2'b11
    } stall_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_STALL,
        ST_T3
    } bus_state_t;
endpackage
`default_nettype wire

// ---- stall_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface stall_if;
    stall_pkg::stall_mode_t mode;
    logic [1:0] count;
    logic req_low;
    logic cyc_start;
    logic cyc_ext;
    stall_pkg::bus_state_t state;
    logic in_stall;
    logic cyc_done;

    modport ctrl (
        output mode, count, req_low, cyc_start, cyc_ext,
        input state, in_stall, cyc_done
    );
    modport seq (
        input mode, count, req_low, cyc_start, cyc_ext,
        output state, in_stall, cyc_done
    );
endinterface
`default_nettype wire

// ---- stall_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
module stall_sequencer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Link to the configuration side
    stall_if.seq bus
);
    import stall_pkg::*;

    bus_state_t next_state;
    logic [1:0] remaining;
    logic [1:0] next_remaining;
    logic ext_q;
    logic extend_q;

    // ========================================
    // Bus-cycle sequencing
    always_comb begin
        next_state = bus.state;
        next_remaining = remaining;
        case (bus.state)
            ST_IDLE: begin
                if (bus.cyc_start) begin
                    next_state = ST_T1;
                end
            end
            ST_T1: begin
                next_state = ST_T2;
            end
            ST_T2: begin
                next_state = ST_T3;
                if (ext_q) begin
                    case (bus.mode)
                        MODE_PROG: begin
                            if (bus.count != COUNT_ZERO) begin
                                next_state = ST_STALL;
                                next_remaining = bus.count;
                            end
                        end
                        MODE_PIN_EXT: begin
                            if (bus.count != COUNT_ZERO) begin
                                next_state = ST_STALL;
                                next_remaining = bus.count;
                            end else if (bus.req_low) begin
                                next_state = ST_STALL;
                                next_remaining = COUNT_ONE;
                            end
                        end
                        MODE_PIN_TRIG: begin
                            if (bus.req_low && bus.count != COUNT_ZERO) begin
                                next_state = ST_STALL;
                                next_remaining = bus.count;
                            end
                        end
                        default: begin
                            next_state = ST_T3;
                        end
                    endcase
                end
            end
            ST_STALL: begin
                if (remaining == COUNT_ONE) begin
                    // The pin only prolongs the last stall state, so a late request cannot shorten a cycle.
                    if (!(extend_q && bus.req_low)) begin
                        next_state = ST_T3;
                    end
                end else begin
                    next_remaining = remaining - COUNT_ONE;
                end
            end
            ST_T3: begin
                next_state = bus.cyc_start ? ST_T1 : ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus.state <= ST_IDLE;
            bus.in_stall <= 1'b0;
            bus.cyc_done <= 1'b0;
            remaining <= COUNT_ZERO;
        end else begin
            bus.state <= next_state;
            bus.in_stall <= (next_state == ST_STALL);
            bus.cyc_done <= (next_state == ST_T3);
            remaining <= next_remaining;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_q <= 1'b0;
            extend_q <= 1'b0;
        end else begin
            if (next_state == ST_T1) begin
                ext_q <= bus.cyc_ext;
            end
            if (bus.state == ST_T2) begin
                extend_q <= (bus.mode == MODE_PIN_EXT);
            end
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_t2_ext(stall_mode_t m, logic [1:0] n);
        bus.state == ST_T2 && ext_q && bus.mode == m && bus.count == n;
    endsequence

    sequence s_to_t3;
        bus.state == ST_T3 && bus.cyc_done && !bus.in_stall;
    endsequence

    property p_prog_three;
        s_t2_ext(MODE_PROG, 2'h3) |=> bus.in_stall [*3] ##1 s_to_t3;
    endproperty
    a_prog_three: assert property (p_prog_three) else $error("prog mode did not give three stalls");

    property p_prog_one;
        s_t2_ext(MODE_PROG, 2'h1) |=> bus.in_stall ##1 s_to_t3;
    endproperty
    a_prog_one: assert property (p_prog_one) else $error("prog mode did not give one stall");

    property p_ext_hold;
        bus.state == ST_STALL && remaining == COUNT_ONE && extend_q && bus.req_low |=> bus.in_stall;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("pin extension lost");

    property p_trig_idle;
        bus.state == ST_T2 && ext_q && bus.mode == MODE_PIN_TRIG && !bus.req_low |=> s_to_t3;
    endproperty
    a_trig_idle: assert property (p_trig_idle) else $error("trigger mode stalled without request");

    property p_trig_two;
        s_t2_ext(MODE_PIN_TRIG, 2'h2) and bus.req_low |=> bus.in_stall [*2] ##1 s_to_t3;
    endproperty
    a_trig_two: assert property (p_trig_two) else $error("trigger mode stall count wrong");

    property p_internal;
        bus.state == ST_T2 && !ext_q |=> s_to_t3;
    endproperty
    a_internal: assert property (p_internal) else $error("internal access stalled");

    property p_none;
        bus.state == ST_T2 && bus.mode == MODE_NONE |=> s_to_t3;
    endproperty
    a_none: assert property (p_none) else $error("no-stall mode stalled");
endmodule
`default_nettype wire

// ---- external_bus_stall_controller.sv ----
// Function
// - The configuration register loads C8 hex on reset and during hardware standby and keeps its value in software standby.
// - The top two register bits ignore writes and always read as one.
// - Bit 4 is a plain read/write storage bit that resets to zero.
// - Mode field bits 3:2 select 00 programmable, 01 no stalls, 10 pin-extended (reset), 11 pin-triggered.
// - Count field bits 1:0 gives zero to three stall states and resets to zero.
// - Programmable mode inserts exactly the counted stall states in every external access and ignores the pin.
// - Pin-extended mode inserts the counted states and keeps adding states while the pin is low in the last one.
// - Pin-triggered mode samples the pin in bus state two and, if low, inserts exactly the counted states.
// - The clock-halving bit gives the peripheral clock at full rate when zero and at half rate when one.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module external_bus_stall_controller #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Power states
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    // CPU bus cycle
    input wire logic cyc_start_i,
    input wire logic cyc_ext_i,
    // External stall request
    input wire logic stall_req_n_i,
    // Bus state and peripheral clock
    output var stall_pkg::bus_state_t bus_state_o,
    output logic stall_o,
    output logic cyc_done_o,
    output logic periph_clk_en_o
);
    import stall_pkg::*;

    generate
        if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
            $error("ADDR_W must lie between 3 and 32");
        end
    endgenerate

    stall_if link ();

    logic [STORED_W-1:0] cfg;
    logic [7:0] cfg_rd;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic write_go;
    logic write_hit;
    logic write_fire;
    logic read_hit;
    logic req_sync1;
    logic req_sync2;

    // ========================================
    // AXI4-Lite write path
    // Address and data may arrive in either order; each is parked until its partner shows up.
    assign write_go = aw_hold && w_hold && !s_axi_bvalid_o;
    assign write_hit = (aw_addr_q[ADDR_W-1:2] == CFG_OFFSET[ADDR_W-1:2]);
    assign write_fire = write_go && write_hit && w_strb_q[0];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_hold <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready_o <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end else if (write_go) begin
                aw_hold <= 1'b0;
            end else if (!aw_hold && !s_axi_bvalid_o) begin
                s_axi_awready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w_hold <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready_o <= 1'b0;
        end else begin
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end else if (write_go) begin
                w_hold <= 1'b0;
            end else if (!w_hold && !s_axi_bvalid_o) begin
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            if (write_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= write_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ========================================
    // Configuration register
    // Hardware standby overrides a write in the same cycle; software standby has no path here at all.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg <= CFG_RESET[STORED_W-1:0];
        end else if (hw_standby_i) begin
            cfg <= CFG_RESET[STORED_W-1:0];
        end else if (write_fire) begin
            cfg <= w_data_q[STORED_W-1:0];
        end
    end

    assign cfg_rd = {RSV_TOP_READ, cfg};

    // ========================================
    // AXI4-Lite read path
    assign read_hit = (s_axi_araddr_i[ADDR_W-1:2] == CFG_OFFSET[ADDR_W-1:2]);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= read_hit ? {24'h00_0000, cfg_rd} : 32'h0000_0000;
                s_axi_rresp_o <= read_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid_o) begin
                if (s_axi_rready_i) begin
                    s_axi_rvalid_o <= 1'b0;
                end
            end else begin
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    // ========================================
    // Stall request synchroniser
    // Two stages cost two cycles of pin latency; the far side must assert the request that early.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_sync1 <= 1'b1;
            req_sync2 <= 1'b1;
        end else begin
            req_sync1 <= stall_req_n_i;
            req_sync2 <= req_sync1;
        end
    end

    // ========================================
    // Sequencer hookup
    assign link.mode = stall_mode_t'(cfg[MODE_HI:MODE_LO]);
    assign link.count = cfg[COUNT_HI:COUNT_LO];
    assign link.req_low = !req_sync2;
    assign link.cyc_start = cyc_start_i;
    assign link.cyc_ext = cyc_ext_i;

    stall_sequencer u_seq (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .bus(link.seq)
    );

    assign bus_state_o = link.state;
    assign stall_o = link.in_stall;
    assign cyc_done_o = link.cyc_done;

    // ========================================
    // Peripheral clock enable
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            periph_clk_en_o <= 1'b1;
        end else if (cfg[CLK_HALVE_BIT]) begin
            periph_clk_en_o <= !periph_clk_en_o;
        end else begin
            periph_clk_en_o <= 1'b1;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_hw_standby;
        hw_standby_i |=> cfg_rd == CFG_RESET;
    endproperty
    a_hw_standby: assert property (p_hw_standby) else $error("standby did not reload config");

    property p_sw_standby;
        sw_standby_i && !hw_standby_i && !write_fire |=> $stable(cfg);
    endproperty
    a_sw_standby: assert property (p_sw_standby) else $error("config changed in software standby");

    property p_top_bits;
        s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY |-> s_axi_rdata_o[7:6] == RSV_TOP_READ;
    endproperty
    a_top_bits: assert property (p_top_bits) else $error("reserved top bits not read as one");

    property p_rsv4;
        write_fire && !hw_standby_i |=> cfg[RSV4_BIT] == $past(w_data_q[RSV4_BIT]);
    endproperty
    a_rsv4: assert property (p_rsv4) else $error("bit four did not store");

    property p_half_rate;
        cfg[CLK_HALVE_BIT] && periph_clk_en_o |=> !periph_clk_en_o;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("halved clock ran at full rate");

    property p_full_rate;
        !cfg[CLK_HALVE_BIT] [*2] |-> periph_clk_en_o;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("full clock skipped a cycle");

    property p_sync;
        link.req_low == !$past(stall_req_n_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("request sync latency wrong");

    property p_write_answer;
        write_go |=> s_axi_bvalid_o && !aw_hold && !w_hold;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response missing");

    property p_b_once;
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");

    property p_read_answer;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read response missing");

    property p_r_once;
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read response repeated");

    property p_aw_closed;
        aw_hold |-> !s_axi_awready_o;
    endproperty
    a_aw_closed: assert property (p_aw_closed) else $error("second write address accepted");

    property p_w_closed;
        w_hold |-> !s_axi_wready_o;
    endproperty
    a_w_closed: assert property (p_w_closed) else $error("second write data accepted");

    property p_bad_write;
        write_go && !write_hit && !hw_standby_i |=> $stable(cfg);
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("unmapped write changed config");

    property p_mode_field;
        write_fire && !hw_standby_i |=> link.mode == stall_mode_t'($past(w_data_q[MODE_HI:MODE_LO]));
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("mode field did not store");

    property p_count_field;
        write_fire && !hw_standby_i |=> cfg[COUNT_HI:COUNT_LO] == $past(w_data_q[COUNT_HI:COUNT_LO]);
    endproperty
    a_count_field: assert property (p_count_field) else $error("count field did not store");

    property p_halve_field;
        write_fire && !hw_standby_i |=> cfg[CLK_HALVE_BIT] == $past(w_data_q[CLK_HALVE_BIT]);
    endproperty
    a_halve_field: assert property (p_halve_field) else $error("clock halving bit did not store");
endmodule
`default_nettype wire

// ---- ext_slow_device.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_slow_device (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Chip select from the address decoder
    input wire logic sel_i,
    // Stall request pin
    output logic stall_req_n_o
);
    // ========================================
    // Request pin
    // The chip select is registered onto the pin one cycle later, so a selected slow device always asks for stalls.
    // The flop drives the pin high from reset and whenever the device is not selected.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stall_req_n_o <= 1'h1;
        end else begin
            stall_req_n_o <= ~sel_i;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import stall_pkg::*;
    // ========================================
    // Signals
    logic clk_i, rstn_i, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic hw_sb, sw_sb, cyc_start, cyc_ext, stall_req_n, sel, stall_o, cyc_done_o, periph_clk_en_o;
    bus_state_t bus_state;
    int error_cnt, checks_done, n;

    external_bus_stall_controller i_external_bus_stall_controller (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .hw_standby_i(hw_sb), .sw_standby_i(sw_sb), .cyc_start_i(cyc_start), .cyc_ext_i(cyc_ext),
        .stall_req_n_i(stall_req_n), .bus_state_o(bus_state), .stall_o(stall_o),
        .cyc_done_o(cyc_done_o), .periph_clk_en_o(periph_clk_en_o)
    );

    ext_slow_device i_ext_slow_device (
        .clk_i(clk_i), .rstn_i(rstn_i), .sel_i(sel), .stall_req_n_o(stall_req_n)
    );

    // ========================================
    // Clock and watchdog
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // The whole sequence needs well under a thousand cycles, so this only trips on a hang.
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end

    // ========================================
    // Reporting
    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("unexpected at %0t: %0d stall states, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask

    // ========================================
    // Register bus master
    // Ready and response channels are sampled at the edge, before that edge's updates land.
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] exp_r);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1) begin
                r = bresp;
                bready <= 1'h0;
                break;
            end
        end
        check_word({30'h0, r}, {30'h0, exp_r});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1) begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
        check_word(d, exp_d);
        check_word({30'h0, r}, {30'h0, exp_r});
    endtask

    task automatic set_mode(input logic [1:0] m, input logic [1:0] c);
        wr_chk(CFG_OFFSET[11:0], {28'h0, m, c}, RESP_OKAY);
    endtask

    // ========================================
    // Bus cycle driver
    // Counts the stall states of one cycle; a cycle that never completes yields minus one.
    task automatic run_cyc(input logic ext, output int cnt);
        cnt = 0;
        @(posedge clk_i);
        cyc_start <= 1'h1;
        cyc_ext <= ext;
        @(posedge clk_i);
        cyc_start <= 1'h0;
        for (int t = 0; t < 40; t++) begin
            #1;
            if (stall_o === 1'h1) cnt++;
            if (t == 1) check_word({29'h0, bus_state}, {29'h0, ST_T2});
            if (cyc_done_o === 1'h1) break;
            @(posedge clk_i);
        end
        if (cyc_done_o !== 1'h1) cnt = -1;
    endtask

    task automatic chk_pclk(input logic halve);
        logic prev;
        @(posedge clk_i);
        #1;
        prev = periph_clk_en_o;
        repeat (4) begin
            @(posedge clk_i);
            #1;
            check_word({31'h0, periph_clk_en_o}, halve ? {31'h0, ~prev} : 32'h1);
            prev = periph_clk_en_o;
        end
    endtask

    // ========================================
    // Tests
    initial begin
        error_cnt = 0;
        checks_done = 0;
        rstn_i = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready, hw_sb, sw_sb, cyc_start, cyc_ext, sel} = 10'h0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00C8, RESP_OKAY);
        chk_pclk(1'h0);
        wr_chk(CFG_OFFSET[11:0], 32'h0000_00FF, RESP_OKAY);
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00FF, RESP_OKAY);
        chk_pclk(1'h1);
        wr_chk(CFG_OFFSET[11:0], 32'h0000_0000, RESP_OKAY);
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00C0, RESP_OKAY);
        wr_chk(CFG_OFFSET[11:0], 32'h0000_0010, RESP_OKAY);
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00D0, RESP_OKAY);
        wr_chk(12'h004, 32'h0000_003F, RESP_SLVERR);
        rd_chk(12'h004, 32'h0000_0000, RESP_SLVERR);
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00D0, RESP_OKAY);
        wr_chk(CFG_OFFSET[11:0], 32'h0000_0017, RESP_OKAY);
        @(posedge clk_i);
        sw_sb <= 1'h1;
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00D7, RESP_OKAY);
        @(posedge clk_i);
        sw_sb <= 1'h0;
        hw_sb <= 1'h1;
        wr_chk(CFG_OFFSET[11:0], 32'h0000_0005, RESP_OKAY);
        rd_chk(CFG_OFFSET[11:0], 32'h0000_00C8, RESP_OKAY);
        @(posedge clk_i);
        hw_sb <= 1'h0;
        // Programmable counts with the pin held low, which must be ignored.
        @(posedge clk_i);
        sel <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            set_mode(MODE_PROG, c[1:0]);
            run_cyc(1'h1, n);
            check_range(n, c, c);
        end
        run_cyc(1'h0, n);
        check_range(n, 0, 0);
        set_mode(MODE_NONE, 2'h3);
        run_cyc(1'h1, n);
        check_range(n, 0, 0);
        set_mode(MODE_PIN_TRIG, 2'h2);
        run_cyc(1'h1, n);
        check_range(n, 2, 2);
        @(posedge clk_i);
        sel <= 1'h0;
        repeat (4) @(posedge clk_i);
        run_cyc(1'h1, n);
        check_range(n, 0, 0);
        set_mode(MODE_PIN_EXT, 2'h2);
        run_cyc(1'h1, n);
        check_range(n, 2, 2);
        @(posedge clk_i);
        sel <= 1'h1;
        repeat (3) @(posedge clk_i);
        // Two counted states, then the pin, seen two cycles late through the synchroniser, holds the last six more.
        fork
            run_cyc(1'h1, n);
            begin
                repeat (8) @(posedge clk_i);
                sel <= 1'h0;
            end
        join
        check_range(n, 8, 8);
        end_sim();
    end
endmodule
`default_nettype wire
